//--- hw/ata_pkg.sv
package ata_pkg;

  // task-file offsets on the register port
  localparam logic [3:0] REG_ERR_FEAT   = 4'h1;
  localparam logic [3:0] REG_SEC_CNT    = 4'h2;
  localparam logic [3:0] REG_SEC_NUM    = 4'h3;
  localparam logic [3:0] REG_CYL_LO     = 4'h4;
  localparam logic [3:0] REG_CYL_HI     = 4'h5;
  localparam logic [3:0] REG_DRV_HEAD   = 4'h6;
  localparam logic [3:0] REG_STATUS_CMD = 4'h7;
  localparam logic [3:0] REG_ALT_DEVCTL = 4'he;
  localparam logic [3:0] REG_DRV_ADDR   = 4'hf;

  // status bit positions
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_WF    = 5;
  localparam int ST_SEEK  = 4;
  localparam int ST_DRQ   = 3;
  localparam int ST_CORRECTED_DATA_FLAG  = 2;
  localparam int ST_INDEX = 1;
  localparam int ST_ERR   = 0;

  // device control bit positions
  localparam int DC_SOFT_RESET  = 2;
  localparam int DC_INT_DISABLE = 1;

  // drive address bit positions
  localparam int DA_WRITE_ACTIVE_N = 6;
  localparam int DA_HEAD_LSB       = 2;
  localparam int DA_DRV1_N         = 1;
  localparam int DA_DRV0_N         = 0;

  // drive/head layout
  localparam int DH_DRV      = 4;
  localparam int DH_HEAD_MSB = 3;

  // error register bit positions
  localparam int ERR_BAD_BLOCK   = 7;
  localparam int ERR_UNCORR      = 6;
  localparam int ERR_ID_MISSING  = 4;
  localparam int ERR_ABORTED     = 2;
  localparam int ERR_GENERAL     = 0;
  localparam logic [7:0] ERR_VALID_MASK = 8'hd5;

  // reset values
  localparam logic [7:0] DRV_HEAD_RESET = 8'ha0;
  localparam logic [7:0] TASK_RESET     = 8'h00;
  localparam logic [7:0] ERR_RESET      = 8'h00;

  // smart signature, autosave sector counts and smart command code
  localparam logic [7:0] SIG_CYL_LO      = 8'h4f;
  localparam logic [7:0] SIG_CYL_HI      = 8'hc2;
  localparam logic [7:0] AUTOSAVE_CNT_A  = 8'h00;
  localparam logic [7:0] AUTOSAVE_CNT_B  = 8'hf1;
  localparam logic [7:0] SMART_CMD_CODE  = 8'hb0;

  typedef enum logic [7:0] {
    SUB_READ_DATA   = 8'hd0,
    SUB_READ_THRESH = 8'hd1,
    SUB_AUTOSAVE    = 8'hd2,
    SUB_READ_LOG    = 8'hd5,
    SUB_WRITE_LOG   = 8'hd6,
    SUB_ENABLE      = 8'hd8,
    SUB_DISABLE     = 8'hd9,
    SUB_STATUS      = 8'hda
  } smart_sub_e;

  typedef enum logic [2:0] {
    ACT_NONE    = 3'b000,
    ACT_ENABLE  = 3'b001,
    ACT_DISABLE = 3'b010,
    ACT_NOOP    = 3'b011,
    ACT_FORWARD = 3'b100,
    ACT_ABORT   = 3'b101
  } smart_act_e;

endpackage

//--- hw/ata_status_control_smart.sv
// Behaviour
// [RQ1] status read clears pending interrupt; alternate status read returns same bits, no clear
// [RQ2] bit 7 busy: card owns registers, host writes refused, other bits invalid; device control writes are still accepted while busy
// [RQ3] ready reads 0 from power-up until the card accepts commands
// [RQ4] write fault flag set when a write fault occurred
// [RQ5] seek complete flag set whenever the card is ready
// [RQ6] data request flag set while card needs a data-register transfer
// [RQ7] corrected data flag on corrected error; multi-sector read continues
// [RQ8] index flag always reads zero
// [RQ9] error flag set when previous command failed; cause in error register
// [RQ10] soft reset request holds card in reset until cleared; config untouched
// [RQ11] interrupt disable high blocks interrupts and config int bit; 0 after reset
// [RQ12] device control bits 7..3 and 0 are ignored on writes
// [RQ13] drive address bit 6 reads 0 during a write, else 1
// [RQ14] drive address bits 5..2 are inverted drive/head bits 3..0
// [RQ15] bit 1 low when drive 1 selected, bit 0 when drive 0; bit 7 undefined
// [RQ16] host should avoid mapping drive address register or tri-state bit 7
// [RQ17] smart subcommands decoded from the feature register codes d0..da
// [RQ18] enable and disable need cylinder signature 4f and c2
// [RQ19] enable opens smart features, disable closes them
// [RQ20] smart enabled state is kept in nonvolatile storage
// [RQ21] autosave with count 00 or f1 and signature completes as no-op
// [RQ22] error register bits 7,6,4,2,0 report cause; bits 5,3,1 read zero
// [RQ23] drive/head bits 3..0 hold head number or block address bits 27..24
// [RQ24] bad signature or unknown subcommand ends with error and aborted bit
// [RQ25] interrupt raised at completion or data request, held until status read
module ata_status_control_smart
  import ata_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // host register port
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  // card core status
  input  wire logic       core_busy,
  input  wire logic       core_ready,
  input  wire logic       core_write_fault,
  input  wire logic       core_data_request,
  input  wire logic       core_corrected,
  input  wire logic       core_write_active,
  input  wire logic       core_done,
  input  wire logic       core_error,
  input  wire logic [7:0] core_err_bits,
  input  wire logic       card_is_drive1,
  // commands to the card core
  output logic            cmd_strobe_q,
  output logic      [7:0] cmd_code_q,
  output logic      [7:0] cmd_feature_q,
  output logic      [7:0] drv_head_q,
  output logic            soft_reset_q,
  // nonvolatile smart state
  input  wire logic       smart_nv_value,
  output logic            smart_en_q,
  output logic            nv_write_q,
  // interrupt, also feeds the config register int bit
  output logic            int_request_q
);

  logic [7:0] feature_q, feature_d;
  logic [7:0] sec_cnt_q, sec_cnt_d;
  logic [7:0] sec_num_q, sec_num_d;
  logic [7:0] cyl_lo_q,  cyl_lo_d;
  logic [7:0] cyl_hi_q,  cyl_hi_d;
  logic [7:0] drv_head_d;
  logic [7:0] err_q,     err_d;
  logic       err_flag_q, err_flag_d;
  logic       int_disable_q, int_disable_d;
  logic       soft_reset_d;
  logic       smart_en_d;
  logic       nv_loaded_q, nv_loaded_d;
  logic       nv_write_d;
  logic       cmd_strobe_d;
  logic [7:0] cmd_code_d;
  logic [7:0] cmd_feature_d;
  logic       local_done_q, local_done_d;
  logic [7:0] reg_rdata_d;
  logic [7:0] status_byte;
  logic [7:0] drive_addr_byte;
  logic       busy;
  logic       ready;
  logic       host_owns;
  logic       cmd_write;
  logic       status_read;

  smart_if sm ();

  smart_decoder u_smart_decoder (
    .sm (sm.decoder)
  );

  intr_ctrl u_intr_ctrl (
    .clock         (clock),
    .rst_n         (rst_n),
    .done_evt      (local_done_q || core_done),
    .data_request_flag           (core_data_request),
    .status_read   (status_read),
    .soft_reset    (soft_reset_q),
    .int_disable   (int_disable_q),
    .int_request_q (int_request_q)
  );

  assign busy        = core_busy || soft_reset_q; // [RQ2] [RQ10]
  assign ready       = core_ready && !soft_reset_q; // [RQ3]
  assign host_owns   = !busy;
  assign cmd_write   = reg_wr && host_owns && (reg_addr == REG_STATUS_CMD);
  assign status_read = reg_rd && (reg_addr == REG_STATUS_CMD); // [RQ1]

  assign sm.req      = cmd_write && (reg_wdata == SMART_CMD_CODE);
  assign sm.feature  = feature_q;
  assign sm.sec_cnt  = sec_cnt_q;
  assign sm.cyl_lo   = cyl_lo_q;
  assign sm.cyl_hi   = cyl_hi_q;
  assign sm.smart_on = smart_en_q;

  always_comb begin
    status_byte           = 8'h00;
    status_byte[ST_BUSY]  = busy; // [RQ2]
    status_byte[ST_READY] = ready; // [RQ3]
    status_byte[ST_WF]    = core_write_fault; // [RQ4]
    status_byte[ST_SEEK]  = ready; // [RQ5]
    status_byte[ST_DRQ]   = core_data_request; // [RQ6]
    status_byte[ST_CORRECTED_DATA_FLAG]  = core_corrected; // [RQ7]
    status_byte[ST_INDEX] = 1'b0; // [RQ8]
    status_byte[ST_ERR]   = err_flag_q; // [RQ9]
  end

  always_comb begin
    // bit 7 left low; host side keeps it off the shared bus
    drive_addr_byte                    = 8'h00; // [RQ15] [RQ16]
    drive_addr_byte[DA_WRITE_ACTIVE_N] = !core_write_active; // [RQ13]
    drive_addr_byte[DA_HEAD_LSB +: 4]  = ~drv_head_q[DH_HEAD_MSB:0]; // [RQ14]
    drive_addr_byte[DA_DRV1_N]         = !(drv_head_q[DH_DRV] && card_is_drive1); // [RQ15]
    drive_addr_byte[DA_DRV0_N]         = !(!drv_head_q[DH_DRV] && !card_is_drive1); // [RQ15]
  end

  // register reads
  always_comb begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        REG_ERR_FEAT:   reg_rdata_d = err_q & ERR_VALID_MASK; // [RQ22]
        REG_SEC_CNT:    reg_rdata_d = sec_cnt_q;
        REG_SEC_NUM:    reg_rdata_d = sec_num_q;
        REG_CYL_LO:     reg_rdata_d = cyl_lo_q;
        REG_CYL_HI:     reg_rdata_d = cyl_hi_q;
        REG_DRV_HEAD:   reg_rdata_d = drv_head_q;
        REG_STATUS_CMD: reg_rdata_d = status_byte; // [RQ1]
        REG_ALT_DEVCTL: reg_rdata_d = status_byte; // [RQ1]
        REG_DRV_ADDR:   reg_rdata_d = drive_addr_byte;
        default:        reg_rdata_d = 8'h00;
      endcase
    end
  end

  // device control: reachable even while busy so soft reset can be released
  always_comb begin
    soft_reset_d  = soft_reset_q;
    int_disable_d = int_disable_q;
    if (reg_wr && reg_addr == REG_ALT_DEVCTL) begin
      soft_reset_d  = reg_wdata[DC_SOFT_RESET]; // [RQ10] [RQ12]
      int_disable_d = reg_wdata[DC_INT_DISABLE]; // [RQ11] [RQ12]
    end
  end

  // task file, command launch and error capture
  always_comb begin
    feature_d     = feature_q;
    sec_cnt_d     = sec_cnt_q;
    sec_num_d     = sec_num_q;
    cyl_lo_d      = cyl_lo_q;
    cyl_hi_d      = cyl_hi_q;
    drv_head_d    = drv_head_q;
    err_d         = err_q;
    err_flag_d    = err_flag_q;
    cmd_strobe_d  = 1'b0;
    cmd_code_d    = cmd_code_q;
    cmd_feature_d = cmd_feature_q;
    local_done_d  = 1'b0;
    if (reg_wr && host_owns) begin // [RQ2]
      case (reg_addr)
        REG_ERR_FEAT: feature_d  = reg_wdata;
        REG_SEC_CNT:  sec_cnt_d  = reg_wdata;
        REG_SEC_NUM:  sec_num_d  = reg_wdata;
        REG_CYL_LO:   cyl_lo_d   = reg_wdata;
        REG_CYL_HI:   cyl_hi_d   = reg_wdata;
        REG_DRV_HEAD: drv_head_d = reg_wdata; // [RQ23]
        default:      drv_head_d = drv_head_q;
      endcase
    end
    if (core_done) begin
      err_flag_d = core_error; // [RQ9]
      err_d      = core_error ? (core_err_bits & ERR_VALID_MASK) : ERR_RESET; // [RQ22]
    end
    if (cmd_write) begin
      err_flag_d    = 1'b0;
      err_d         = ERR_RESET;
      cmd_code_d    = reg_wdata;
      cmd_feature_d = feature_q;
      case (sm.act)
        ACT_ENABLE, ACT_DISABLE, ACT_NOOP:
          local_done_d = 1'b1;
        ACT_ABORT: begin
          local_done_d          = 1'b1;
          err_flag_d            = 1'b1; // [RQ24]
          err_d[ERR_ABORTED]    = 1'b1; // [RQ24]
        end
        default:
          cmd_strobe_d = 1'b1;
      endcase
    end
    if (soft_reset_q) begin
      // config registers live elsewhere and are not touched here
      feature_d    = TASK_RESET; // [RQ10]
      sec_cnt_d    = TASK_RESET;
      sec_num_d    = TASK_RESET;
      cyl_lo_d     = TASK_RESET;
      cyl_hi_d     = TASK_RESET;
      drv_head_d   = DRV_HEAD_RESET;
      err_d        = ERR_RESET;
      err_flag_d   = 1'b0;
      cmd_strobe_d = 1'b0;
      local_done_d = 1'b0;
    end
  end

  // smart state: loaded from storage once, written back on every change
  always_comb begin
    smart_en_d  = smart_en_q;
    nv_loaded_d = 1'b1;
    nv_write_d  = 1'b0;
    if (!nv_loaded_q) begin
      smart_en_d = smart_nv_value; // [RQ20]
    end else if (cmd_write && !soft_reset_q) begin
      if (sm.act == ACT_ENABLE) begin
        smart_en_d = 1'b1; // [RQ19]
        nv_write_d = 1'b1; // [RQ20]
      end else if (sm.act == ACT_DISABLE) begin
        smart_en_d = 1'b0; // [RQ19]
        nv_write_d = 1'b1; // [RQ20]
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      feature_q     <= TASK_RESET;
      sec_cnt_q     <= TASK_RESET;
      sec_num_q     <= TASK_RESET;
      cyl_lo_q      <= TASK_RESET;
      cyl_hi_q      <= TASK_RESET;
      drv_head_q    <= DRV_HEAD_RESET;
      err_q         <= ERR_RESET;
      err_flag_q    <= 1'b0;
      int_disable_q <= 1'b0; // [RQ11]
      soft_reset_q  <= 1'b0;
      smart_en_q    <= 1'b0;
      nv_loaded_q   <= 1'b0;
      nv_write_q    <= 1'b0;
      cmd_strobe_q  <= 1'b0;
      cmd_code_q    <= 8'h00;
      cmd_feature_q <= 8'h00;
      local_done_q  <= 1'b0;
      reg_rdata_q   <= 8'h00;
    end else begin
      feature_q     <= feature_d;
      sec_cnt_q     <= sec_cnt_d;
      sec_num_q     <= sec_num_d;
      cyl_lo_q      <= cyl_lo_d;
      cyl_hi_q      <= cyl_hi_d;
      drv_head_q    <= drv_head_d;
      err_q         <= err_d;
      err_flag_q    <= err_flag_d;
      int_disable_q <= int_disable_d;
      soft_reset_q  <= soft_reset_d;
      smart_en_q    <= smart_en_d;
      nv_loaded_q   <= nv_loaded_d;
      nv_write_q    <= nv_write_d;
      cmd_strobe_q  <= cmd_strobe_d;
      cmd_code_q    <= cmd_code_d;
      cmd_feature_q <= cmd_feature_d;
      local_done_q  <= local_done_d;
      reg_rdata_q   <= reg_rdata_d;
    end
  end

endmodule

//--- hw/intr_ctrl.sv
module intr_ctrl (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // events
  input  wire logic done_evt,
  input  wire logic data_request_flag,
  input  wire logic status_read,
  input  wire logic soft_reset,
  input  wire logic int_disable,
  // request
  output logic      int_request_q
);

  logic pending_q;
  logic pending_d;
  logic drq_prev_q;
  logic drq_prev_d;
  logic int_request_d;

  always_comb begin
    drq_prev_d = data_request_flag;
    // a new event in the clearing cycle still wins
    if (done_evt || (data_request_flag && !drq_prev_q)) begin
      pending_d = 1'b1; // [RQ25]
    end else if (status_read || soft_reset) begin
      pending_d = 1'b0; // [RQ1]
    end else begin
      pending_d = pending_q;
    end
    int_request_d = pending_d && !int_disable; // [RQ11]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending_q     <= 1'b0;
      drq_prev_q    <= 1'b0;
      int_request_q <= 1'b0;
    end else begin
      pending_q     <= pending_d;
      drq_prev_q    <= drq_prev_d;
      int_request_q <= int_request_d;
    end
  end

endmodule

//--- hw/smart_decoder.sv
module smart_decoder
  import ata_pkg::*;
(
  // request from the task file, verdict back
  smart_if.decoder sm
);

  function automatic logic sig_ok(input logic [7:0] lo, input logic [7:0] hi);
    sig_ok = (lo == SIG_CYL_LO) && (hi == SIG_CYL_HI);
  endfunction

  always_comb begin
    sm.act = ACT_NONE;
    if (sm.req) begin
      case (sm.feature)
        SUB_ENABLE:
          sm.act = sig_ok(sm.cyl_lo, sm.cyl_hi) ? ACT_ENABLE : ACT_ABORT; // [RQ17] [RQ18] [RQ24]
        SUB_DISABLE:
          sm.act = sig_ok(sm.cyl_lo, sm.cyl_hi) ? ACT_DISABLE : ACT_ABORT; // [RQ18] [RQ24]
        SUB_AUTOSAVE: begin
          // attributes are always current, so a valid autosave does nothing
          if (sig_ok(sm.cyl_lo, sm.cyl_hi) &&
              (sm.sec_cnt == AUTOSAVE_CNT_A || sm.sec_cnt == AUTOSAVE_CNT_B)) begin
            sm.act = ACT_NOOP; // [RQ21]
          end else begin
            sm.act = ACT_ABORT; // [RQ24]
          end
        end
        SUB_READ_DATA, SUB_READ_THRESH, SUB_READ_LOG, SUB_WRITE_LOG, SUB_STATUS:
          sm.act = (sig_ok(sm.cyl_lo, sm.cyl_hi) && sm.smart_on) ? ACT_FORWARD : ACT_ABORT; // [RQ17] [RQ19]
        default:
          sm.act = ACT_ABORT; // [RQ24]
      endcase
    end
  end

endmodule

//--- hw/smart_if.sv
interface smart_if;
  import ata_pkg::*;

  logic       req;
  logic [7:0] feature;
  logic [7:0] sec_cnt;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic       smart_on;
  smart_act_e act;

  modport requester (output req, output feature, output sec_cnt, output cyl_lo, output cyl_hi,
                     output smart_on, input act);
  modport decoder   (input req, input feature, input sec_cnt, input cyl_lo, input cyl_hi,
                     input smart_on, output act);
endinterface

//--- verification/ata_status_control_smart_assertions.sv
module ata_status_control_smart_assertions
  import ata_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  // core and outputs
  input wire logic       core_busy,
  input wire logic       core_ready,
  input wire logic       core_write_fault,
  input wire logic       core_data_request,
  input wire logic       core_write_active,
  input wire logic       core_done,
  input wire logic [7:0] drv_head_q,
  input wire logic       soft_reset_q,
  input wire logic       nv_write_q,
  input wire logic       int_request_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic st_rd;
  logic dc_wr;
  assign st_rd = reg_rd && reg_addr == REG_STATUS_CMD;
  assign dc_wr = reg_wr && reg_addr == REG_ALT_DEVCTL;

  a_busy_bit: assert property (st_rd && core_busy |=> reg_rdata_q[ST_BUSY])
    else $error("busy bit missing");
  a_status_fields: assert property (st_rd && !core_busy && !soft_reset_q |=>
    reg_rdata_q[ST_READY] == $past(core_ready) && reg_rdata_q[ST_SEEK] == $past(core_ready)
    && reg_rdata_q[ST_WF] == $past(core_write_fault) && reg_rdata_q[ST_DRQ] == $past(core_data_request))
    else $error("status fields wrong");
  a_index_zero: assert property (st_rd |=> !reg_rdata_q[ST_INDEX])
    else $error("index bit set");
  a_read_clears: assert property (st_rd && !reg_wr && !$past(reg_wr) && !core_done
    && !$rose(core_data_request) |=> !int_request_q)
    else $error("status read kept interrupt");
  a_alt_keeps: assert property (int_request_q && reg_rd && reg_addr == REG_ALT_DEVCTL && !reg_wr
    |=> int_request_q)
    else $error("alternate read cleared interrupt");
  a_drive_echo: assert property (reg_rd && reg_addr == REG_DRV_ADDR && !reg_wr |=>
    reg_rdata_q[5:2] == ~drv_head_q[3:0] && reg_rdata_q[DA_WRITE_ACTIVE_N] == !$past(core_write_active))
    else $error("drive address echo wrong");
  a_soft_enter: assert property (dc_wr && reg_wdata[DC_SOFT_RESET] |=> soft_reset_q)
    else $error("soft reset not entered");
  a_soft_leave: assert property (dc_wr && !reg_wdata[DC_SOFT_RESET] |=> !soft_reset_q)
    else $error("soft reset not left");
  a_soft_busy: assert property (soft_reset_q && st_rd |=> reg_rdata_q[7:6] == 2'b10)
    else $error("soft reset status wrong");
  // mask lands in the disable flop first, the request flop one edge later
  a_int_mask: assert property (dc_wr && reg_wdata[DC_INT_DISABLE] && !reg_rd |-> ##3 !int_request_q)
    else $error("interrupt not masked");
  a_nv_cause: assert property (nv_write_q |-> $past(reg_wr) && $past(reg_addr) == REG_STATUS_CMD
    && $past(reg_wdata) == SMART_CMD_CODE)
    else $error("stray nonvolatile write");
endmodule

bind ata_status_control_smart ata_status_control_smart_assertions chk (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .core_busy(core_busy), .core_ready(core_ready), .core_write_fault(core_write_fault),
  .core_data_request(core_data_request), .core_write_active(core_write_active), .core_done(core_done),
  .drv_head_q(drv_head_q), .soft_reset_q(soft_reset_q), .nv_write_q(nv_write_q),
  .int_request_q(int_request_q));

//--- verification/ata_status_control_smart_tb_top.sv
module ata_status_control_smart_tb_top import ata_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic       reg_rd = 1'b0;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic       core_ready = 1'b0;
  logic       core_wf = 1'b0;
  logic       core_drq = 1'b0;
  logic       core_corrected_data_flag = 1'b0;
  logic       core_wa = 1'b0;
  logic       drive1 = 1'b0;
  logic       core_fail = 1'b0;
  logic       nv_store = 1'b1;
  logic       busy_force = 1'b0;
  logic       model_busy, core_done, core_error, cmd_strobe_q, soft_reset_q;
  logic       smart_en_q, nv_write_q, int_request_q;
  logic [7:0] core_err_bits, reg_rdata_q, cmd_code_q, cmd_feature_q, drv_head_q;
  logic [7:0] d;
  int         errors = 0;
  int         checked = 0;
  int         nv_seen, fwd_seen, int_seen;

  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (nv_write_q === 1'b1) begin
      nv_seen++;
      nv_store <= smart_en_q;
    end
    if (cmd_strobe_q === 1'b1) fwd_seen++;
    if (int_request_q === 1'b1) int_seen++;
  end

  core_model core (.clock(clock), .rst_n(rst_n), .cmd_strobe_q(cmd_strobe_q), .soft_reset_q(soft_reset_q),
    .fail(core_fail), .core_busy(model_busy), .core_done(core_done), .core_error(core_error),
    .core_err_bits(core_err_bits));
  ata_status_control_smart uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .core_busy(model_busy | busy_force),
    .core_ready(core_ready), .core_write_fault(core_wf), .core_data_request(core_drq),
    .core_corrected(core_corrected_data_flag), .core_write_active(core_wa), .core_done(core_done),
    .core_error(core_error), .core_err_bits(core_err_bits), .card_is_drive1(drive1),
    .cmd_strobe_q(cmd_strobe_q), .cmd_code_q(cmd_code_q), .cmd_feature_q(cmd_feature_q),
    .drv_head_q(drv_head_q), .soft_reset_q(soft_reset_q), .smart_nv_value(nv_store),
    .smart_en_q(smart_en_q), .nv_write_q(nv_write_q), .int_request_q(int_request_q));

  task automatic report_and_stop();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
  endtask
  task automatic smart(input logic [7:0] f, c, lo, input logic en, input logic [7:0] err, input int nv, fw);
    logic [7:0] v;
    wr(REG_ERR_FEAT, f);
    wr(REG_SEC_CNT, c);
    wr(REG_CYL_LO, lo);
    wr(REG_CYL_HI, SIG_CYL_HI);
    nv_seen = 0;
    fwd_seen = 0;
    int_seen = 0;
    wr(REG_STATUS_CMD, SMART_CMD_CODE);
    tick(12);
    chk("smart_en", {7'h0, en}, {7'h0, smart_en_q});
    chk("nv_writes", 8'(nv), 8'(nv_seen));
    chk("forwarded", 8'(fw), 8'(fwd_seen));
    chk("int_raised", 8'h01, {7'h0, int_seen != 0});
    if (fw != 0) chk("feature", f, cmd_feature_q);
    if (fw != 0) chk("cmd_code", SMART_CMD_CODE, cmd_code_q);
    rd(REG_ERR_FEAT, v);
    chk("error_reg", err, v);
    rd(REG_STATUS_CMD, v);
    chk("status", {7'h28, err != 8'h00}, v);
  endtask

  initial begin
    #50000;
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    tick(2);
    chk("smart_en", 8'h01, {7'h0, smart_en_q});
    chk("drv_head", DRV_HEAD_RESET, drv_head_q);
    rd(REG_STATUS_CMD, d);
    chk("status", 8'h00, d);
    core_ready <= 1'b1;
    rd(REG_STATUS_CMD, d);
    chk("status", 8'h50, d);
    rd(4'h0, d);
    chk("unmapped", 8'h00, d);
    {core_wf, core_corrected_data_flag} <= 2'b11;
    rd(REG_ALT_DEVCTL, d);
    chk("alt_status", 8'h74, d);
    {core_wf, core_corrected_data_flag} <= 2'b00;
    core_drq <= 1'b1;
    tick(3);
    chk("int", 8'h01, {7'h0, int_request_q});
    rd(REG_ALT_DEVCTL, d);
    chk("alt_status", 8'h58, d);
    chk("int", 8'h01, {7'h0, int_request_q});
    rd(REG_STATUS_CMD, d);
    chk("int", 8'h00, {7'h0, int_request_q});
    core_drq <= 1'b0;
    wr(REG_ALT_DEVCTL, 8'h02);
    core_drq <= 1'b1;
    tick(3);
    chk("int", 8'h00, {7'h0, int_request_q});
    wr(REG_ALT_DEVCTL, 8'hf9);
    tick(2);
    chk("int", 8'h01, {7'h0, int_request_q});
    chk("soft_reset", 8'h00, {7'h0, soft_reset_q});
    core_drq <= 1'b0;
    wr(REG_DRV_HEAD, 8'ha5);
    rd(REG_DRV_ADDR, d);
    chk("drive_addr", 8'h6a, d);
    chk("drv_head", 8'ha5, drv_head_q);
    drive1 <= 1'b1;
    core_wa <= 1'b1;
    wr(REG_DRV_HEAD, 8'hb3);
    rd(REG_DRV_ADDR, d);
    chk("drive_addr", 8'h31, d);
    core_wa <= 1'b0;
    busy_force <= 1'b1;
    wr(REG_DRV_HEAD, 8'he0);
    rd(REG_DRV_HEAD, d);
    chk("refused_write", 8'hb3, d);
    busy_force <= 1'b0;
    drive1 <= 1'b0;
    wr(REG_ALT_DEVCTL, 8'h04);
    tick(1);
    chk("soft_reset", 8'h01, {7'h0, soft_reset_q});
    rd(REG_STATUS_CMD, d);
    chk("status_busy", 8'h80, d & 8'hc0);
    chk("drv_head", DRV_HEAD_RESET, drv_head_q);
    chk("smart_en", 8'h01, {7'h0, smart_en_q});
    wr(REG_ALT_DEVCTL, 8'h00);
    rd(REG_STATUS_CMD, d);
    smart(SUB_DISABLE, 8'h00, SIG_CYL_LO, 1'b0, 8'h00, 1, 0);
    smart(SUB_READ_DATA, 8'h00, SIG_CYL_LO, 1'b0, 8'h04, 0, 0);
    smart(SUB_ENABLE, 8'h00, SIG_CYL_LO, 1'b1, 8'h00, 1, 0);
    smart(SUB_AUTOSAVE, AUTOSAVE_CNT_B, SIG_CYL_LO, 1'b1, 8'h00, 0, 0);
    smart(SUB_AUTOSAVE, AUTOSAVE_CNT_A, SIG_CYL_LO, 1'b1, 8'h00, 0, 0);
    smart(SUB_AUTOSAVE, 8'h05, SIG_CYL_LO, 1'b1, 8'h04, 0, 0);
    smart(SUB_ENABLE, 8'h00, 8'h4e, 1'b1, 8'h04, 0, 0);
    smart(8'hd3, 8'h00, SIG_CYL_LO, 1'b1, 8'h04, 0, 0);
    smart(SUB_READ_DATA, 8'h00, SIG_CYL_LO, 1'b1, 8'h00, 0, 1);
    smart(SUB_READ_THRESH, 8'h00, SIG_CYL_LO, 1'b1, 8'h00, 0, 1);
    smart(SUB_READ_LOG, 8'h00, SIG_CYL_LO, 1'b1, 8'h00, 0, 1);
    smart(SUB_WRITE_LOG, 8'h00, SIG_CYL_LO, 1'b1, 8'h00, 0, 1);
    core_fail <= 1'b1;
    smart(SUB_STATUS, 8'h00, SIG_CYL_LO, 1'b1, ERR_VALID_MASK, 0, 1);
    core_fail <= 1'b0;
    smart(SUB_DISABLE, 8'h00, SIG_CYL_LO, 1'b0, 8'h00, 1, 0);
    wr(REG_STATUS_CMD, 8'h20);
    tick(1);
    chk("cmd_code", 8'h20, cmd_code_q);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    tick(2);
    chk("smart_en", 8'h00, {7'h0, smart_en_q});
    report_and_stop();
  end
endmodule

//--- verification/core_model.sv
module core_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // from the block
  input  wire logic       cmd_strobe_q,
  input  wire logic       soft_reset_q,
  // scenario control
  input  wire logic       fail,
  // core status
  output logic            core_busy,
  output logic            core_done,
  output logic            core_error,
  output logic      [7:0] core_err_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      core_busy <= 1'b0;
      core_done <= 1'b0;
      core_error <= 1'b0;
      core_err_bits <= 8'h00;
    end else begin
      core_done <= 1'b0;
      // junk outside done, so a stray sample shows
      core_error <= ~core_error;
      core_err_bits <= ~core_err_bits;
      if (soft_reset_q) begin
        cnt_q <= 3'h0;
        core_busy <= 1'b0;
      end else if (cmd_strobe_q) begin
        cnt_q <= 3'h4;
        core_busy <= 1'b1;
      end else if (cnt_q == 3'h1) begin
        cnt_q <= 3'h0;
        core_busy <= 1'b0;
        core_done <= 1'b1;
        core_error <= fail;
        core_err_bits <= fail ? 8'hff : 8'h00;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule
